// ---- verilog/adcsc_pkg.sv ----
// Package of constants and types for the converter sequencer control block
package adcsc_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CLKPIN = 8'h04;
	localparam logic [7:0] ADDR_RES_HI = 8'h08;
	localparam logic [7:0] ADDR_RES_LO = 8'h0c;
	localparam logic [7:0] ADDR_INTCTL = 8'h10;

	// Field positions
	localparam int CTRL_CHAN_LSB = 0;
	localparam int CTRL_FLAG_BIT = 6;
	localparam int CTRL_START_BIT = 7;
	localparam int CLKPIN_DIV_LSB = 0;
	localparam int CLKPIN_PIN_LSB = 4;
	localparam int INT_GIE_BIT = 0;
	localparam int INT_EIE_BIT = 1;
	localparam int INT_REQ_BIT = 2;
	localparam int RES_LO_LSB = 4;

	// Reset values and the all-pins configuration code
	localparam logic FLAG_RESET = 1'b1;
	localparam logic [3:0] PIN_CFG_OFF = 4'h0;
	localparam logic [3:0] PIN_CFG_ALL = 4'hf;

	// Divider ratios per code, smallest first
	localparam logic [7:0] DIV_RATIO0 = 8'h02;
	localparam logic [7:0] DIV_RATIO1 = 8'h08;
	localparam logic [7:0] DIV_RATIO2 = 8'h10;
	localparam logic [7:0] DIV_RATIO3 = 8'h20;

	// Converter clock periods per conversion
	localparam logic [6:0] CONV_TICKS = 7'h4c;

	typedef enum logic [1:0] {PH_OFF, PH_IDLE, PH_RESET, PH_CONV} adcsc_phase_e;

	// Signals toward the analog converter core
	typedef struct packed {
		logic reset;
		logic power_down;
		logic run;
		logic [3:0] channel;
	} adcsc_conv_s;

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} adcsc_div_s;

	typedef struct packed {
		adcsc_phase_e phase;
		logic [3:0] chan;
		logic start;
		logic flag;
		logic [1:0] div_sel;
		logic [3:0] pin_cfg;
		logic gie;
		logic eie;
		logic req;
		logic [11:0] result;
		logic [6:0] tick_cnt;
		logic done;
		logic [31:0] prdata;
		logic pslverr;
	} adcsc_state_s;

endpackage

// ---- verilog/adcsc_clkdiv.sv ----
// Converter clock divider producing one tick per converter clock period
module adcsc_clkdiv (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic clear,
	input wire logic [1:0] div_sel,
	// Tick out
	output logic tick
);

	adcsc_pkg::adcsc_div_s r_reg;
	adcsc_pkg::adcsc_div_s r_next;
	logic [7:0] ratio;

	always_comb begin
		unique case (div_sel)
			2'h0: ratio = adcsc_pkg::DIV_RATIO0;
			2'h1: ratio = adcsc_pkg::DIV_RATIO1;
			2'h2: ratio = adcsc_pkg::DIV_RATIO2;
			2'h3: ratio = adcsc_pkg::DIV_RATIO3;
		endcase
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (clear) begin
			// Restart so the first period of a conversion is a full one
			r_next.cnt = 8'h00;
		end else if (r_reg.cnt >= ratio - 8'h01) begin
			r_next.cnt = 8'h00;
			r_next.tick = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign tick = r_reg.tick;

endmodule

// ---- verilog/adcsc_pinmap.sv ----
// Shared pin function map: analog selection, pull-high and direction override
module adcsc_pinmap (
	// Configuration
	input wire logic [3:0] pin_cfg,
	// Port side settings
	input wire logic [15:0] port_dir_oe,
	input wire logic [15:0] pullup_opt,
	// Effective pin control
	output logic [15:0] analog_en,
	output logic [15:0] port_oe,
	output logic [15:0] pullup_en
);

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			// Code n enables pins 0..n-1; code 1111 enables all
			analog_en[i] = (4'(i) < pin_cfg) || (pin_cfg == adcsc_pkg::PIN_CFG_ALL);
		end
	end

	assign port_oe = port_dir_oe & ~analog_en;
	assign pullup_en = pullup_opt & ~analog_en;

endmodule

// ---- verilog/adcsc_top.sv ----
// Converter sequencer control: APB registers, start handshake and conversion timing
//
// Design decisions made here: the register addresses and the APB register port.
module adcsc_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog converter core
	output adcsc_pkg::adcsc_conv_s conv_ctl,
	output logic conv_tick,
	input wire logic [11:0] conv_result,
	output logic conv_done,
	// Shared port pins
	input wire logic [15:0] port_dir_oe,
	input wire logic [15:0] pullup_opt,
	output logic [15:0] analog_en,
	output logic [15:0] port_oe,
	output logic [15:0] pullup_en,
	// Interrupt to processor
	output logic adc_irq
);

	adcsc_pkg::adcsc_state_s r_reg;
	adcsc_pkg::adcsc_state_s r_next;
	logic tick;
	logic wr;
	logic rd_setup;
	logic start_rise;
	logic pin_change;
	logic [7:0] rd_byte;
	logic rd_hit;

	adcsc_clkdiv u_clkdiv (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clear(r_reg.phase != adcsc_pkg::PH_CONV),
		.div_sel(r_reg.div_sel),
		.tick(tick)
	);

	adcsc_pinmap u_pinmap (
		.pin_cfg(r_reg.pin_cfg),
		.port_dir_oe(port_dir_oe),
		.pullup_opt(pullup_opt),
		.analog_en(analog_en),
		.port_oe(port_oe),
		.pullup_en(pullup_en)
	);

	// Zero wait states: every access phase completes at once
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;

	// Read data is captured in the setup cycle so prdata leaves a flip-flop
	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		unique case (paddr)
			adcsc_pkg::ADDR_CTRL: begin
				rd_byte[adcsc_pkg::CTRL_START_BIT] = r_reg.start;
				rd_byte[adcsc_pkg::CTRL_FLAG_BIT] = r_reg.flag;
				rd_byte[adcsc_pkg::CTRL_CHAN_LSB +: 4] = r_reg.chan;
			end
			adcsc_pkg::ADDR_CLKPIN: begin
				rd_byte[adcsc_pkg::CLKPIN_PIN_LSB +: 4] = r_reg.pin_cfg;
				rd_byte[adcsc_pkg::CLKPIN_DIV_LSB +: 2] = r_reg.div_sel;
			end
			adcsc_pkg::ADDR_RES_HI: begin
				rd_byte = r_reg.result[11:4];
			end
			adcsc_pkg::ADDR_RES_LO: begin
				rd_byte[adcsc_pkg::RES_LO_LSB +: 4] = r_reg.result[3:0];
			end
			adcsc_pkg::ADDR_INTCTL: begin
				rd_byte[adcsc_pkg::INT_GIE_BIT] = r_reg.gie;
				rd_byte[adcsc_pkg::INT_EIE_BIT] = r_reg.eie;
				rd_byte[adcsc_pkg::INT_REQ_BIT] = r_reg.req;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		start_rise = 1'b0;
		pin_change = 1'b0;

		if (rd_setup) begin
			r_next.prdata = {24'h000000, rd_byte};
			r_next.pslverr = ~rd_hit;
		end else if (psel && !pwrite) begin
			r_next.pslverr = r_reg.pslverr;
		end else if (rd_setup == 1'b0 && psel) begin
			r_next.pslverr = r_reg.pslverr;
		end
		// Write errors are decided in the setup cycle as well
		if (rd_setup && pwrite) begin
			r_next.pslverr = ~rd_hit || paddr == adcsc_pkg::ADDR_RES_HI
				|| paddr == adcsc_pkg::ADDR_RES_LO;
		end

		if (wr) begin
			unique case (paddr)
				adcsc_pkg::ADDR_CTRL: begin
					r_next.chan = pwdata[adcsc_pkg::CTRL_CHAN_LSB +: 4];
					r_next.start = pwdata[adcsc_pkg::CTRL_START_BIT];
				end
				adcsc_pkg::ADDR_CLKPIN: begin
					r_next.div_sel = pwdata[adcsc_pkg::CLKPIN_DIV_LSB +: 2];
					r_next.pin_cfg = pwdata[adcsc_pkg::CLKPIN_PIN_LSB +: 4];
				end
				adcsc_pkg::ADDR_INTCTL: begin
					r_next.gie = pwdata[adcsc_pkg::INT_GIE_BIT];
					r_next.eie = pwdata[adcsc_pkg::INT_EIE_BIT];
					r_next.req = pwdata[adcsc_pkg::INT_REQ_BIT];
				end
				default: begin
					r_next.gie = r_reg.gie;
				end
			endcase
		end

		start_rise = r_next.start & ~r_reg.start;
		pin_change = r_next.pin_cfg != r_reg.pin_cfg;

		unique case (r_reg.phase)
			adcsc_pkg::PH_OFF: begin
				r_next.phase = adcsc_pkg::PH_IDLE;
			end
			adcsc_pkg::PH_IDLE: begin
				r_next.phase = adcsc_pkg::PH_IDLE;
			end
			adcsc_pkg::PH_RESET: begin
				r_next.flag = 1'b1;
				if (!r_next.start) begin
					// Falling edge completes the pulse and launches the cycle
					r_next.phase = adcsc_pkg::PH_CONV;
					r_next.tick_cnt = 7'h00;
				end
			end
			adcsc_pkg::PH_CONV: begin
				if (tick) begin
					if (r_reg.tick_cnt == adcsc_pkg::CONV_TICKS - 7'h01) begin
						r_next.phase = adcsc_pkg::PH_IDLE;
						r_next.flag = 1'b0;
						r_next.result = conv_result;
						r_next.req = 1'b1;
						r_next.done = 1'b1;
					end else begin
						r_next.tick_cnt = r_reg.tick_cnt + 7'h01;
					end
				end
			end
		endcase

		// Overrides in priority order; a completion set above still wins over a clear
		if (r_next.pin_cfg == adcsc_pkg::PIN_CFG_OFF) begin
			// Powered down; the way back passes through PH_IDLE, so a new start pulse is needed
			r_next.phase = adcsc_pkg::PH_OFF;
			r_next.done = 1'b0;
			r_next.req = r_next.req & ~r_next.done;
		end else if (pin_change) begin
			// Abort and leave the flag as it stood until software pulses start
			r_next.phase = adcsc_pkg::PH_IDLE;
			r_next.done = 1'b0;
		end else if (start_rise || (r_next.start && r_reg.phase == adcsc_pkg::PH_OFF)) begin
			r_next.phase = adcsc_pkg::PH_RESET;
			r_next.flag = 1'b1;
			r_next.done = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.flag <= adcsc_pkg::FLAG_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// Converter core control
	always_comb begin
		conv_ctl.reset = r_reg.phase == adcsc_pkg::PH_RESET;
		conv_ctl.power_down = r_reg.phase == adcsc_pkg::PH_OFF;
		conv_ctl.run = r_reg.phase == adcsc_pkg::PH_CONV;
		conv_ctl.channel = r_reg.chan;
	end

	// Gated so a tick launched on the edge that ends or aborts a conversion never leaks out
	assign conv_tick = tick & conv_ctl.run;
	assign conv_done = r_reg.done;
	assign prdata = r_reg.prdata;
	assign pslverr = r_reg.pslverr & psel & penable;
	assign adc_irq = r_reg.req & r_reg.gie & r_reg.eie;

endmodule

// ---- dv/adcsc_core_model.sv ----
// Behavioural model of the analog converter core
module adcsc_core_model (
	// Clock
	input wire logic core_clk,
	// Converter control and result
	input wire adcsc_pkg::adcsc_conv_s conv_ctl,
	output logic [11:0] conv_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] last = 12'h000;
	always_ff @(posedge core_clk) begin
		last <= conv_result;
	end
	// Result only holds while converting; otherwise it keeps changing
	assign conv_result = conv_ctl.run ? {conv_ctl.channel, ~conv_ctl.channel,
		conv_ctl.channel} : ~last;
endmodule

// ---- dv/adcsc_assertions.sv ----
// Concurrent checks on the converter sequencer control ports
module adcsc_assertions (
	// Clock, reset and bus
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	// Converter and pins
	input wire adcsc_pkg::adcsc_conv_s conv_ctl,
	input wire logic conv_tick,
	input wire logic conv_done,
	input wire logic [15:0] port_dir_oe,
	input wire logic [15:0] pullup_opt,
	input wire logic [15:0] analog_en,
	input wire logic [15:0] port_oe,
	input wire logic [15:0] pullup_en,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr;
	logic [7:0] ticks;
	assign wr = psel && penable && pwrite;
	// Ticks since the converter left reset
	always_ff @(posedge core_clk) begin
		if (!rst_n || conv_ctl.reset)
			ticks <= 8'h00;
		else if (conv_tick)
			ticks <= ticks + 8'h01;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_START: assert property (
		wr && paddr == 8'h00 && pwdata[7] && !conv_ctl.power_down |=> conv_ctl.reset)
		else $error("start write did not reset converter");
	AST_RUN: assert property (
		$fell(conv_ctl.reset) && $past(wr) && $past(paddr) == 8'h00
		&& !conv_ctl.power_down |-> conv_ctl.run)
		else $error("conversion did not start");
	AST_TICK: assert property (conv_tick |-> conv_ctl.run)
		else $error("tick outside conversion");
	AST_LEN: assert property (conv_done |-> ticks == 8'h4c)
		else $error("conversion length wrong");
	AST_DOWN: assert property (
		conv_ctl.power_down == (analog_en == 16'h0000))
		else $error("power down mismatch");
	AST_PINS: assert property (
		port_oe == (port_dir_oe & ~analog_en) && pullup_en == (pullup_opt & ~analog_en))
		else $error("pin override wrong");
	AST_GROUP: assert property (
		((analog_en + 16'h0001) & analog_en) == 16'h0000)
		else $error("analog pins not contiguous");
	AST_CHAN: assert property (
		wr && paddr == 8'h00 |=> conv_ctl.channel == $past(pwdata[3:0]))
		else $error("channel not routed");
	cover property (conv_done);
	cover property ($rose(conv_ctl.reset));
	cover property (pslverr);
endmodule

bind adcsc_top adcsc_assertions u_adcsc_assertions (.*);

// ---- dv/adcsc_top_tb.sv ----
// Self-checking bench for the converter sequencer control
module adcsc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
	logic conv_tick, conv_done, adc_irq;
	logic [7:0] paddr, rdat;
	logic [3:0] ch;
	logic [31:0] pwdata, prdata;
	logic [11:0] conv_result;
	logic [15:0] port_dir_oe, pullup_opt, analog_en, port_oe, pullup_en;
	logic [15:0] pins_exp;
	adcsc_pkg::adcsc_conv_s conv_ctl;
	int fails, checks_done, n;
	logic [7:0] ratio [4] = '{adcsc_pkg::DIV_RATIO0, adcsc_pkg::DIV_RATIO1,
		adcsc_pkg::DIV_RATIO2, adcsc_pkg::DIV_RATIO3};
	adcsc_top u_adcsc_top (.*);
	adcsc_core_model u_adcsc_core_model (.*);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input logic [15:0] s, input logic [15:0] e, input string nm);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task results;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		i = 0;
		// Access phase holds until pready is seen high at a rising edge
		@(posedge core_clk);
		while (pready !== 1'b1 && i < 50) begin
			@(posedge core_clk);
			i++;
		end
		if (i == 50) begin
			fails++;
			results;
		end
		rdat = prdata[7:0];
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let this edge's register updates settle before callers compare outputs
		#1;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
		port_dir_oe = 16'ha5c3;
		pullup_opt = 16'h3cf0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		bus(0, adcsc_pkg::ADDR_CTRL, 8'h00);
		chk(rdat, 8'h40, "control at reset");
		chk(conv_ctl.power_down, 1'b1, "power down at reset");
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			bus(1, adcsc_pkg::ADDR_CLKPIN, {c[3:0], 4'h0});
			pins_exp = (c == 15) ? 16'hffff : 16'((1 << c) - 1);
			chk(analog_en, pins_exp, "analog pins");
			chk(port_oe, 16'ha5c3 & ~pins_exp, "port direction");
			chk(pullup_en, 16'h3cf0 & ~pins_exp, "pull-high");
		end
		bus(1, adcsc_pkg::ADDR_RES_HI, 8'hff);
		chk(rerr, 1'b1, "result write error");
		bus(0, 8'h14, 8'h00);
		chk({rerr, rdat}, 9'h100, "unmapped read");
		bus(1, adcsc_pkg::ADDR_CLKPIN, 8'h00);
		bus(1, adcsc_pkg::ADDR_CTRL, 8'h80);
		bus(1, adcsc_pkg::ADDR_CTRL, 8'h00);
		chk(conv_ctl.run, 1'b0, "run while powered down");
		$display("test pins done");
		for (int d = 0; d < 4; d++) begin
			ch = 4'(d * 5 + 1);
			bus(1, adcsc_pkg::ADDR_INTCTL, d[7:0]);
			// Code 00 is run for timing only: the model core has no minimum clock period
			bus(1, adcsc_pkg::ADDR_CLKPIN, {6'h3c, d[1:0]});
			bus(1, adcsc_pkg::ADDR_CTRL, {4'h8, ch});
			bus(0, adcsc_pkg::ADDR_CTRL, 8'h00);
			chk(rdat, {4'hc, ch}, "flag during reset");
			bus(1, adcsc_pkg::ADDR_CTRL, {4'h0, ch});
			n = 0;
			#1;
			while (conv_done !== 1'b1 && n < 3000) begin
				@(posedge core_clk);
				#1;
				n++;
			end
			if (n == 3000) begin
				fails++;
				results;
			end
			chk(n >= 76 * ratio[d] && n <= 76 * ratio[d] + 4, 1'b1, "conversion time");
			bus(0, adcsc_pkg::ADDR_CTRL, 8'h00);
			chk(rdat, {4'h0, ch}, "flag after conversion");
			bus(0, adcsc_pkg::ADDR_RES_HI, 8'h00);
			chk(rdat, {ch, ~ch}, "result high");
			bus(0, adcsc_pkg::ADDR_RES_LO, 8'h00);
			chk(rdat, {ch, 4'h0}, "result low");
			bus(0, adcsc_pkg::ADDR_INTCTL, 8'h00);
			chk(rdat, {5'h00, 1'b1, d[1:0]}, "interrupt request");
			chk(adc_irq, d == 3, "interrupt line");
		end
		bus(1, adcsc_pkg::ADDR_INTCTL, 8'h03);
		chk(adc_irq, 1'b0, "interrupt cleared");
		$display("test conversions done");
		results;
	end
endmodule
